//--- logic/ivm_regs.svh
`ifndef IVM_REGS_SVH
`define IVM_REGS_SVH

// table geometry
`define IVM_NUM_VEC 40
`define IVM_VNUM_W 6
`define IVM_VADDR_W 8
`define IVM_PIN_COUNT_DEF 48
`define IVM_PINS_MID 40
`define IVM_PINS_MAX 48

// fixed entries
`define IVM_VEC_RESET 6'h00
`define IVM_VEC_NMI 6'h01
`define IVM_VEC_FIRST_MASKABLE 6'h02

// maskable sources
`define IVM_VEC_VOLTAGE_LEVEL_MONITOR 6'h02
`define IVM_VEC_RTC 6'h03
`define IVM_VEC_PERIODIC_TICK 6'h04
`define IVM_VEC_CUSTOM_LOGIC_UNIT 6'h05
`define IVM_VEC_PIN_GROUP_A 6'h06
`define IVM_VEC_WIDE_TIMER_0_OVF 6'h07
`define IVM_VEC_WIDE_TIMER_0_UNF 6'h08
`define IVM_VEC_WIDE_TIMER_0_CMP0 6'h09
`define IVM_VEC_WIDE_TIMER_0_CMP2 6'h0b
`define IVM_VEC_CAPTURE_TIMER_0 6'h0c
`define IVM_VEC_CAPTURE_TIMER_1 6'h0d
`define IVM_VEC_TWO_WIRE_TARGET 6'h0e
`define IVM_VEC_TWO_WIRE_CONTROLLER 6'h0f
`define IVM_VEC_SERIAL_PERIPH_PORT 6'h10
`define IVM_VEC_SERIAL_PORT_0_RX 6'h11
`define IVM_VEC_PIN_GROUP_D 6'h14
`define IVM_VEC_ANALOG_COMPARATOR 6'h15
`define IVM_VEC_ANALOG_CONVERTER_RES 6'h16
`define IVM_VEC_ANALOG_CONVERTER_WIN 6'h17
`define IVM_VEC_PIN_GROUP_C 6'h18
`define IVM_VEC_CAPTURE_TIMER_2 6'h19
`define IVM_VEC_SERIAL_PORT_1_RX 6'h1a
`define IVM_VEC_PIN_GROUP_F 6'h1d
`define IVM_VEC_MEMORY_CONTROLLER 6'h1e
`define IVM_VEC_SERIAL_PORT_2_RX 6'h1f
`define IVM_VEC_PIN_GROUP_B 6'h22
`define IVM_VEC_PIN_GROUP_E 6'h23
`define IVM_VEC_CAPTURE_TIMER_3 6'h24
`define IVM_VEC_SERIAL_PORT_3_RX 6'h25
`define IVM_VEC_LAST 6'h27

// vector addresses of table landmarks
`define IVM_ADDR_PIN_GROUP_A 8'h0c
`define IVM_ADDR_WIDE_TIMER_0_CMP2 8'h16
`define IVM_ADDR_SERIAL_PERIPH_PORT 8'h20
`define IVM_ADDR_SERIAL_PORT_0_RX 8'h22
`define IVM_ADDR_ANALOG_CONVERTER_WIN 8'h2e
`define IVM_ADDR_MEMORY_CONTROLLER 8'h3c
`define IVM_ADDR_SERIAL_PORT_2_RX 8'h3e
`define IVM_ADDR_SERIAL_PORT_2_TXDONE 8'h42
`define IVM_ADDR_PIN_GROUP_B 8'h44
`define IVM_ADDR_SERIAL_PORT_3_RX 8'h4a

// serial port sub-source offsets from the receive vector
`define IVM_SP_EMPTY_OFS 6'h01
`define IVM_SP_TXDONE_OFS 6'h02

`endif

//--- logic/ivm_pkg.sv
`include "ivm_regs.svh"

package ivm_pkg;

  typedef logic [`IVM_NUM_VEC-1:0] ivm_src_t;
  typedef logic [`IVM_VNUM_W-1:0] ivm_num_t;
  typedef logic [`IVM_VADDR_W-1:0] ivm_addr_t;

  // what the core sees
  typedef struct packed {
    logic req;
    logic nmi;
    ivm_num_t num;
    ivm_addr_t addr;
  } ivm_vec_t;

  typedef enum {
    IVM_BOOT,
    IVM_RUN
  } ivm_state_t;

  // vector n sits at word address 2*n
  function automatic ivm_addr_t ivm_vec_addr(input ivm_num_t n);
    return {1'b0, n, 1'b0};
  endfunction

  // which maskable vectors exist for a pin-count variant
  function automatic ivm_src_t ivm_present_mask(input int pins);
    ivm_src_t m;
    m = '0;
    for (int i = int'(`IVM_VEC_FIRST_MASKABLE); i <= int'(`IVM_VEC_LAST); i++) begin
      if (i == int'(`IVM_VEC_PIN_GROUP_B)) begin
        m[i] = (pins >= `IVM_PINS_MAX);
      end else if (i >= int'(`IVM_VEC_PIN_GROUP_E)) begin
        m[i] = (pins >= `IVM_PINS_MID);
      end else begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

endpackage

//--- logic/ivm_flag_bank.sv
module ivm_flag_bank #(
  parameter int N = 40,
  parameter logic [N-1:0] PRESENT = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // peripheral side
  input wire logic [N-1:0] setPulse,
  input wire logic [N-1:0] clrPulse,
  input wire logic enWrite,
  input wire logic [N-1:0] enData,
  // state
  output logic [N-1:0] flags,
  output logic [N-1:0] enables
);

  logic [N-1:0] flag_reg;
  logic [N-1:0] flag_next;
  logic [N-1:0] enable_reg;
  logic [N-1:0] enable_next;

  // flag set wins
  // an event in the clearing cycle must survive, so set is or-ed last
  assign flag_next = ((flag_reg & ~clrPulse) | setPulse) & PRESENT;
  assign enable_next = enWrite ? (enData & PRESENT) : enable_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_reg <= '0;
      enable_reg <= '0;
    end else begin
      flag_reg <= flag_next;
      enable_reg <= enable_next;
    end
  end

  assign flags = flag_reg;
  assign enables = enable_reg;

endmodule

//--- logic/ivm_prio_pick.sv
module ivm_prio_pick #(
  parameter int N = 40,
  parameter int W = 6
) (
  // candidates
  input wire logic [N-1:0] pending,
  // winner
  output logic valid,
  output logic [W-1:0] idx
);

  // lowest number wins
  // scanning downward lets the last hit, the lowest bit, stand
  always_comb begin
    valid = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i]) begin
        valid = 1'b1;
        idx = W'(i);
      end
    end
  end

endmodule

//--- logic/ivm_vector_map.sv
// Contract
// - a peripheral event sets its own flag bit in the flag bank.
// - each source has its own enable bit that software writes to turn it on or off.
// - a source requests only while both its enable and its flag are set.
// - a request stays until its flag is cleared; taking the vector does not drop it.
// - no maskable request reaches the core while the global enable is low.
// - every vector belongs to one source and vector n sits at address 2*n.
// - vector 0 is the reset entry and vector 1 the non-maskable memory check interrupt.
// - vectors 2 to 6 are level monitor, real-time counter, periodic tick, custom logic and pin group a.
// - vectors 7 to 11 are wide timer overflow, split underflow and compare channels 0 to 2.
// - vectors 12 to 16 are capture timers 0 and 1, two-wire target and controller, serial periph port.
// - vectors 17 to 19 are serial port 0 receive, data empty and transmit complete.
// - vectors 20 to 23 are pin group d, comparator, converter result and converter window.
// - vectors 24 to 30 are pin group c, capture timer 2, serial port 1 trio, pin group f, memory ready.
// - vectors 31 to 33 are serial port 2 receive, data empty and transmit complete.
// - vector 34 exists only on the largest variant, vectors 35 and 36 on the 40 and 48 pin variants.
// - vectors 37 to 39 for serial port 3 exist only on the higher pin-count variants.
`include "ivm_regs.svh"

module ivm_vector_map
  import ivm_pkg::*;
#(
  parameter int PIN_COUNT = `IVM_PIN_COUNT_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // peripheral events and flag clears, one bit per vector
  input wire ivm_pkg::ivm_src_t srcSet,
  input wire ivm_pkg::ivm_src_t srcClear,
  // enable writes
  input wire logic enWrite,
  input wire ivm_pkg::ivm_src_t enData,
  // global enable and memory check fault
  input wire logic globalIrqEnable,
  input wire logic nmiCrc,
  input wire logic nmiClear,
  // core side
  input wire logic vecAck,
  output ivm_pkg::ivm_vec_t irqVec,
  output logic vecTaken,
  // state seen by software through the peripherals
  output ivm_pkg::ivm_src_t flagState,
  output ivm_pkg::ivm_src_t enableState,
  output logic nmiPending
);
  import ivm_pkg::*;

  localparam ivm_src_t PRESENT = ivm_present_mask(PIN_COUNT);

  ivm_state_t state_reg;
  ivm_state_t state_next;
  logic nmi_reg;
  logic nmi_next;
  ivm_vec_t vec_reg;
  ivm_vec_t vec_next;
  logic taken_reg;
  logic taken_next;

  wire ivm_src_t flags;
  wire ivm_src_t enables;
  wire ivm_src_t qualified;
  wire ivm_src_t pending;
  wire logic pickValid;
  wire ivm_num_t pickIdx;
  wire logic bootPending;
  wire logic ackNow;
  wire logic ackBoot;

  ivm_flag_bank #(
    .N(`IVM_NUM_VEC),
    .PRESENT(PRESENT)
  ) flagBank (
    .clk(clk),
    .rst_n(rst_n),
    .setPulse(srcSet),
    .clrPulse(srcClear),
    .enWrite(enWrite),
    .enData(enData),
    .flags(flags),
    .enables(enables)
  );

  // level follows the flag
  // the core's acknowledge is not an input here, so taking a vector cannot drop it
  assign qualified = flags & enables;

  assign bootPending = (state_reg == IVM_BOOT);

  // reset entry and nmi bypass the gate
  assign pending = (qualified & {`IVM_NUM_VEC{globalIrqEnable}})
    | (ivm_src_t'(bootPending) << `IVM_VEC_RESET)
    | (ivm_src_t'(nmi_reg) << `IVM_VEC_NMI);

  ivm_prio_pick #(
    .N(`IVM_NUM_VEC),
    .W(`IVM_VNUM_W)
  ) picker (
    .pending(pending),
    .valid(pickValid),
    .idx(pickIdx)
  );

  assign ackNow = vecAck && vec_reg.req;
  assign ackBoot = ackNow && (vec_reg.num == `IVM_VEC_RESET);

  assign nmi_next = (nmi_reg && !nmiClear) || nmiCrc;

  always_comb begin
    case (state_reg)
      IVM_BOOT: state_next = ackBoot ? IVM_RUN : IVM_BOOT;
      IVM_RUN: state_next = IVM_RUN;
      default: state_next = IVM_BOOT;
    endcase
  end

  // vector presented to the core
  // bit index equals vector number, so the table is the wiring itself
  assign vec_next = '{
    req: pickValid,
    nmi: pickValid && (pickIdx == `IVM_VEC_NMI),
    num: pickIdx,
    addr: ivm_vec_addr(pickIdx)
  };

  assign taken_next = ackNow;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= IVM_BOOT;
      nmi_reg <= 1'b0;
      vec_reg <= '0;
      taken_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      nmi_reg <= nmi_next;
      vec_reg <= vec_next;
      taken_reg <= taken_next;
    end
  end

  assign irqVec = vec_reg;
  assign vecTaken = taken_reg;
  assign flagState = flags;
  assign enableState = enables;
  assign nmiPending = nmi_reg;

  // helper for ordering checks
  wire ivm_src_t belowPick = (ivm_src_t'(1) << pickIdx) - ivm_src_t'(1);

  a_flag_sets: assert property (
    @(posedge clk) disable iff (!rst_n)
    |(srcSet & PRESENT) |=> ((flags & $past(srcSet & PRESENT)) == $past(srcSet & PRESENT))
  ) else $error("peripheral event did not set its flag");

  a_enable_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    enWrite |=> (enables == ($past(enData) & PRESENT))
  ) else $error("enable write not taken");

  a_pick_qualified: assert property (
    @(posedge clk) disable iff (!rst_n)
    pickValid && (pickIdx >= `IVM_VEC_FIRST_MASKABLE)
      |-> flags[pickIdx] && enables[pickIdx] && globalIrqEnable
  ) else $error("request without flag, enable and global enable");

  a_req_persists: assert property (
    @(posedge clk) disable iff (!rst_n)
    (|qualified && globalIrqEnable) |=> irqVec.req
  ) else $error("active request dropped while flag still set");

  a_global_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    !globalIrqEnable |=> !irqVec.req || (irqVec.num < `IVM_VEC_FIRST_MASKABLE)
  ) else $error("maskable request passed a low global enable");

  a_addr_twice: assert property (
    @(posedge clk) disable iff (!rst_n)
    irqVec.req |-> (irqVec.addr[0] == 1'b0) && (irqVec.addr[`IVM_VADDR_W-1:1] == 7'(irqVec.num))
  ) else $error("vector address is not twice its number");

  a_boot_first: assert property (
    @(posedge clk)
    rst_n && !$past(rst_n) |=> irqVec.req && (irqVec.num == `IVM_VEC_RESET) && !irqVec.nmi
  ) else $error("reset entry not presented after reset");

  a_nmi_ungated: assert property (
    @(posedge clk) disable iff (!rst_n)
    nmi_reg && !bootPending |=> irqVec.req && irqVec.nmi && (irqVec.num == `IVM_VEC_NMI)
  ) else $error("memory check interrupt not presented");

  a_sole_source: assert property (
    @(posedge clk) disable iff (!rst_n)
    $onehot(pending) |=> irqVec.req && ((ivm_src_t'(1) << irqVec.num) == $past(pending))
  ) else $error("single source mapped to wrong vector");

  a_absent_silent: assert property (
    @(posedge clk) disable iff (!rst_n)
    (flags & ~PRESENT) == '0
  ) else $error("absent vector raised a flag");

  a_lowest_first: assert property (
    @(posedge clk) disable iff (!rst_n)
    pickValid |-> ((pending & belowPick) == '0) ##1 (irqVec.num == $past(pickIdx))
  ) else $error("a lower pending vector was passed over");

  a_flag_holds: assert property (
    @(posedge clk) disable iff (!rst_n)
    |(flags & ~srcClear) |=> ((flags & $past(flags & ~srcClear)) == $past(flags & ~srcClear))
  ) else $error("flag dropped without a clear");

  a_flag_clears: assert property (
    @(posedge clk) disable iff (!rst_n)
    |(srcClear & ~srcSet) |=> ((flags & $past(srcClear & ~srcSet)) == '0)
  ) else $error("cleared flag still set");

  a_enable_holds: assert property (
    @(posedge clk) disable iff (!rst_n)
    !enWrite |=> $stable(enables)
  ) else $error("enable bits moved without a write");

  a_masked_silent: assert property (
    @(posedge clk) disable iff (!rst_n)
    ((flags & enables) == '0) && !nmi_reg && !bootPending |=> !irqVec.req
  ) else $error("request offered with no enabled flag");

  a_ack_keeps_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    vecAck && irqVec.req && (irqVec.num >= `IVM_VEC_FIRST_MASKABLE) && flags[irqVec.num] && !srcClear[irqVec.num]
      |=> flags[$past(irqVec.num)]
  ) else $error("taking a vector dropped its flag");

  a_nmi_ack_keeps: assert property (
    @(posedge clk) disable iff (!rst_n)
    vecAck && irqVec.nmi && nmiPending && !nmiClear |=> nmiPending
  ) else $error("taking the nmi vector dropped it");

  a_taken_after_ack: assert property (
    @(posedge clk) disable iff (!rst_n)
    vecAck && irqVec.req |=> vecTaken
  ) else $error("acknowledged vector not reported taken");

  a_taken_only_ack: assert property (
    @(posedge clk) disable iff (!rst_n)
    vecTaken |-> $past(vecAck && irqVec.req)
  ) else $error("taken pulse without an acknowledge");

  a_gate_low_masks: assert property (
    @(posedge clk) disable iff (!rst_n)
    !globalIrqEnable |-> ((pending >> `IVM_VEC_FIRST_MASKABLE) == '0)
  ) else $error("maskable source pending with global enable low");

  a_nmi_sets: assert property (
    @(posedge clk) disable iff (!rst_n)
    nmiCrc |=> nmiPending
  ) else $error("memory check fault did not raise nmi");

  a_nmi_clears: assert property (
    @(posedge clk) disable iff (!rst_n)
    nmiClear && !nmiCrc |=> !nmiPending
  ) else $error("nmi clear not taken");

  a_boot_once: assert property (
    @(posedge clk) disable iff (!rst_n)
    !bootPending |=> !bootPending
  ) else $error("reset entry returned without a reset");

  a_boot_held: assert property (
    @(posedge clk) disable iff (!rst_n)
    bootPending && !ackBoot |=> bootPending
  ) else $error("reset entry retired without its acknowledge");

  a_pin_a_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    irqVec.req && (irqVec.num == `IVM_VEC_PIN_GROUP_A) |-> (irqVec.addr == `IVM_ADDR_PIN_GROUP_A)
  ) else $error("pin group a vector at wrong address");

  a_timer_cmp2_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    irqVec.req && (irqVec.num == `IVM_VEC_WIDE_TIMER_0_CMP2) |-> (irqVec.addr == `IVM_ADDR_WIDE_TIMER_0_CMP2)
  ) else $error("wide timer compare 2 vector at wrong address");

  a_periph_port_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    irqVec.req && (irqVec.num == `IVM_VEC_SERIAL_PERIPH_PORT) |-> (irqVec.addr == `IVM_ADDR_SERIAL_PERIPH_PORT)
  ) else $error("serial periph port vector at wrong address");

  a_port0_rx_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    irqVec.req && (irqVec.num == `IVM_VEC_SERIAL_PORT_0_RX) |-> (irqVec.addr == `IVM_ADDR_SERIAL_PORT_0_RX)
  ) else $error("serial port 0 receive vector at wrong address");

  a_conv_window_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    irqVec.req && (irqVec.num == `IVM_VEC_ANALOG_CONVERTER_WIN) |-> (irqVec.addr == `IVM_ADDR_ANALOG_CONVERTER_WIN)
  ) else $error("converter window vector at wrong address");

  a_mem_ready_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    irqVec.req && (irqVec.num == `IVM_VEC_MEMORY_CONTROLLER) |-> (irqVec.addr == `IVM_ADDR_MEMORY_CONTROLLER)
  ) else $error("memory ready vector at wrong address");

  a_port2_rx_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    irqVec.req && (irqVec.num == `IVM_VEC_SERIAL_PORT_2_RX) |-> (irqVec.addr == `IVM_ADDR_SERIAL_PORT_2_RX)
  ) else $error("serial port 2 receive vector at wrong address");

  a_port2_tx_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    irqVec.req && (irqVec.num == (`IVM_VEC_SERIAL_PORT_2_RX + `IVM_SP_TXDONE_OFS))
      |-> (irqVec.addr == `IVM_ADDR_SERIAL_PORT_2_TXDONE)
  ) else $error("serial port 2 transmit vector at wrong address");

  a_pin_b_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    irqVec.req && (irqVec.num == `IVM_VEC_PIN_GROUP_B) |-> (irqVec.addr == `IVM_ADDR_PIN_GROUP_B)
  ) else $error("pin group b vector at wrong address");

  a_port3_rx_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    irqVec.req && (irqVec.num == `IVM_VEC_SERIAL_PORT_3_RX) |-> (irqVec.addr == `IVM_ADDR_SERIAL_PORT_3_RX)
  ) else $error("serial port 3 receive vector at wrong address");

  a_group_b_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    (PIN_COUNT < `IVM_PINS_MAX) |-> !flags[`IVM_VEC_PIN_GROUP_B]
  ) else $error("pin group b flag on a smaller variant");

  a_upper_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    (PIN_COUNT < `IVM_PINS_MID) |-> (flags[`IVM_VEC_LAST:`IVM_VEC_PIN_GROUP_E] == 5'h00)
  ) else $error("upper vector flag on a small variant");

endmodule

//--- sim/ivm_core_model.sv
module ivm_core_model
  import ivm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // vector port
  input wire ivm_pkg::ivm_vec_t irqVec,
  input wire logic ackOn,
  input wire logic [3:0] slow,
  output logic vecAck
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] waitCnt = 4'h0;
  initial vecAck = 1'b0;
  // stalls a chosen number of cycles, then acks for one cycle only
  always @(negedge clk) begin
    if (!rst_n || !ackOn || irqVec.req !== 1'b1 || vecAck) begin
      vecAck <= 1'b0;
      waitCnt <= 4'h0;
    end else if (waitCnt >= slow) begin
      vecAck <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

//--- sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ivm_pkg::*;
  `define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %0t %s", $time, m); end end
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ivm_src_t srcSet = '0;
  ivm_src_t srcClear = '0;
  ivm_src_t enData = '0;
  logic enWrite = 1'b0;
  logic globalIrqEnable = 1'b0;
  logic nmiCrc = 1'b0;
  logic nmiClear = 1'b0;
  logic ackOn = 1'b0;
  logic [3:0] slow = 4'h0;
  logic vecAck;
  logic vecTaken;
  logic nmiPending;
  ivm_vec_t irqVec;
  ivm_src_t flagState;
  ivm_src_t enableState;
  ivm_src_t flag40;
  ivm_src_t en40;
  ivm_src_t flag28;
  ivm_src_t en28;
  int fails = 0;
  int checked = 0;
  logic [31:0] seed = 32'hcb2c;
  always #25 clk = ~clk;
  ivm_vector_map #(.PIN_COUNT(48)) ivm_vector_map_inst (.clk(clk), .rst_n(rst_n), .srcSet(srcSet),
    .srcClear(srcClear), .enWrite(enWrite), .enData(enData), .globalIrqEnable(globalIrqEnable),
    .nmiCrc(nmiCrc), .nmiClear(nmiClear), .vecAck(vecAck), .irqVec(irqVec), .vecTaken(vecTaken),
    .flagState(flagState), .enableState(enableState), .nmiPending(nmiPending));
  // smaller variants share every input so absent vectors can be seen
  ivm_vector_map #(.PIN_COUNT(40)) ivm_vector_map_inst_40 (.clk(clk), .rst_n(rst_n), .srcSet(srcSet),
    .srcClear(srcClear), .enWrite(enWrite), .enData(enData), .globalIrqEnable(globalIrqEnable),
    .nmiCrc(nmiCrc), .nmiClear(nmiClear), .vecAck(vecAck), .irqVec(), .vecTaken(),
    .flagState(flag40), .enableState(en40), .nmiPending());
  ivm_vector_map #(.PIN_COUNT(28)) ivm_vector_map_inst_28 (.clk(clk), .rst_n(rst_n), .srcSet(srcSet),
    .srcClear(srcClear), .enWrite(enWrite), .enData(enData), .globalIrqEnable(globalIrqEnable),
    .nmiCrc(nmiCrc), .nmiClear(nmiClear), .vecAck(vecAck), .irqVec(), .vecTaken(),
    .flagState(flag28), .enableState(en28), .nmiPending());
  ivm_core_model ivm_core_model_inst (.clk(clk), .rst_n(rst_n), .irqVec(irqVec), .ackOn(ackOn),
    .slow(slow), .vecAck(vecAck));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // lowest maskable number wins; bits 0 and 1 never come from flags
  function automatic ivm_num_t lowest(input ivm_src_t p);
    lowest = '0;
    for (int i = 39; i >= 2; i--) begin
      if (p[i]) lowest = ivm_num_t'(i);
    end
  endfunction
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic events(input ivm_src_t s, input ivm_src_t c);
    srcSet = s;
    srcClear = c;
    step(1);
    srcSet = '0;
    srcClear = '0;
  endtask
  task automatic enable(input ivm_src_t e);
    enData = e;
    enWrite = 1'b1;
    step(1);
    enWrite = 1'b0;
  endtask
  // bounded wait; the pulse stands one cycle, so look at every falling edge
  task automatic take(input logic [3:0] s);
    int k;
    slow = s;
    ackOn = 1'b1;
    for (k = 0; k < 40 && vecTaken !== 1'b1; k++) step(1);
    ackOn = 1'b0;
    `CHK(k < 40, 1'b1, "no vector taken")
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    end_sim();
  end
  initial begin
    ivm_src_t p;
    step(12);
    rst_n = 1'b1;
    step(2);
    `CHK(irqVec, 16'h8000, "reset entry")
    take(4'h0);
    step(2);
    `CHK(irqVec.req, 1'b0, "reset entry retired")
    nmiCrc = 1'b1;
    step(1);
    nmiCrc = 1'b0;
    step(1);
    `CHK(irqVec, 16'hc102, "nmi with global low")
    take(4'h2);
    step(1);
    `CHK({irqVec.req, irqVec.num, nmiPending}, 8'h83, "nmi kept after ack")
    nmiClear = 1'b1;
    step(1);
    nmiClear = 1'b0;
    step(1);
    `CHK(irqVec.req, 1'b0, "nmi cleared")
    globalIrqEnable = 1'b1;
    enable('1);
    `CHK(enableState, {{38{1'b1}}, 2'b00}, "enable bank")
    `CHK({en40, en28}, 80'hfbfffffffc_03fffffffc, "variant enables")
    for (int n = 2; n < 40; n++) begin
      events(ivm_src_t'(1) << n, '0);
      `CHK(flagState[n], 1'b1, "flag set")
      `CHK({flag40[n], flag28[n]}, {n != 34, n < 34}, "variant flags")
      step(1);
      `CHK({irqVec.req, irqVec.num, irqVec.addr}, {1'b1, ivm_num_t'(n), 8'(2 * n)}, "map")
      take(4'(n % 4));
      step(1);
      `CHK({irqVec.req, irqVec.num}, {1'b1, ivm_num_t'(n)}, "ack keeps request")
      events('0, ivm_src_t'(1) << n);
      step(1);
      `CHK(irqVec.req, 1'b0, "cleared flag drops request")
    end
    globalIrqEnable = 1'b0;
    events(40'h200, 40'h200);
    step(1);
    `CHK({flagState[9], irqVec.req}, 2'b10, "set beats clear, global hides")
    globalIrqEnable = 1'b1;
    step(2);
    `CHK(irqVec.num, 6'h09, "global on")
    enable(40'hfffffffdff);
    step(1);
    `CHK({flagState[9], irqVec.req}, 2'b10, "enable off hides flag")
    enable('1);
    events('0, '1);
    // hand-written top pair first, then random sets
    for (int r = 0; r < 30; r++) begin
      seed = lfsr(seed);
      p = (r == 0) ? 40'hc000000000 : {seed, seed[15:8]};
      events(p, '0);
      step(1);
      `CHK({irqVec.req, irqVec.num}, {|p[39:2], lowest(p)}, "lowest first")
      events('0, '1);
    end
    // nmi outranks every maskable source
    nmiCrc = 1'b1;
    events(40'h4, '0);
    nmiCrc = 1'b0;
    step(1);
    `CHK({irqVec.req, irqVec.nmi, irqVec.num}, 8'hc1, "nmi before vector 2")
    nmiClear = 1'b1;
    step(1);
    nmiClear = 1'b0;
    step(1);
    `CHK({irqVec.req, irqVec.num}, 7'h42, "vector 2 after nmi")
    // second reset in mid-run brings the reset entry back
    rst_n = 1'b0;
    step(3);
    `CHK({flagState, enableState, nmiPending, irqVec.req}, 82'h0, "mid-run reset")
    rst_n = 1'b1;
    step(2);
    `CHK(irqVec, 16'h8000, "reset entry again")
    end_sim();
  end
endmodule
